// File: rtl/cstx_edge_detect.sv
// rise and fall detector for a vector of same-clock levels
`timescale 1ns/1ps
module cstx_edge_detect #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign rise[i] = level[i] & ~prev_reg[i];
            assign fall[i] = ~level[i] & prev_reg[i];
        end
    endgenerate
endmodule

// File: rtl/cstx_evt_if.sv
// event, flag and interrupt signals between the register block and the flag store
`timescale 1ns/1ps
interface cstx_evt_if;
    logic [4:0] set;
    logic [4:0] wr_clr;
    logic       rd_clr;
    logic [4:0] enable;
    logic       rx_live;
    logic [4:0] flags;
    logic       irq;

    modport ctl (
        output set,
        output wr_clr,
        output rd_clr,
        output enable,
        output rx_live,
        input  flags,
        input  irq
    );
    modport flg (
        input  set,
        input  wr_clr,
        input  rd_clr,
        input  enable,
        input  rx_live,
        output flags,
        output irq
    );
endinterface

// File: rtl/cstx_irq_flags.sv
// sticky event flags with clear on read or write, and the interrupt level
`timescale 1ns/1ps
module cstx_irq_flags (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    cstx_evt_if.flg   ev
);
    logic [3:0] flag_reg;
    logic [3:0] flag_next;
    logic       rx_reg;

    // a set in the clearing cycle survives
    always_comb begin
        flag_next = flag_reg;
        if (ev.rd_clr) begin
            flag_next = 4'h0;
        end
        flag_next = (flag_next & ~ev.wr_clr[3:0]) | ev.set[3:0];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_reg <= cstx_pkg::RST_EVT[3:0];
        end else begin
            flag_reg <= flag_next; // see (R11) see (R12) see (R13) see (R14)
        end
    end

    // mirrors the port sources; reads and clear writes leave it, only the sources clear it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_reg <= cstx_pkg::RST_BIT;
        end else begin
            rx_reg <= ev.rx_live; // see (R10)
        end
    end

    assign ev.flags = {rx_reg, flag_reg};
    assign ev.irq   = |(ev.flags & ev.enable); // see (R19)
endmodule

// File: rtl/cstx_pkg.sv
// shared constants for the transmit-port status and interrupt block
package cstx_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int EVT_W  = 5;

    localparam logic [7:0] ADDR_PASS_CTRL = 8'h34;
    localparam logic [7:0] ADDR_STATUS    = 8'h35;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h36;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h37;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'h38;
    localparam logic [7:0] ADDR_PATT_HI   = 8'h39;
    localparam logic [7:0] ADDR_PATT_LO   = 8'h3A;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h50;

    localparam int BIT_PASS_MODE = 3;
    localparam int BIT_ST_PASS   = 0;
    localparam int BIT_ST_SYNC   = 1;

    localparam int EV_PASS_GAIN = 0;
    localparam int EV_PASS_LOSS = 1;
    localparam int EV_ALIGNED   = 2;
    localparam int EV_ALIGN_ERR = 3;
    localparam int EV_RX_SOURCE = 4;

    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [4:0] RST_EVT   = 5'h00;
    localparam logic       RST_BIT   = 1'b0;
endpackage

// File: rtl/cstx_status_irq.sv
// transmit-port status, interrupt enable and flags, and characterization pattern
//
// Function
// (R1) sync status bit, forced low when disabled
// (R2) pass when any enabled port valid
// (R3) unsynchronized mode: error clears pass
// (R4) synchronized mode: pass means data available
// (R5) enable bit 4 gates receive-port interrupt
// (R6) enable bit 3 gates alignment error
// (R7) enable bit 2 gates aligned assertion
// (R8) enable bit 1 gates pass loss
// (R9) enable bit 0 gates pass gain
// (R10) flag 4 mirrors forwarded port interrupts
// (R11) flag 3 latches alignment error, read clears
// (R12) flag 2 latches aligned rise, read clears
// (R13) flag 1 latches port pass loss
// (R14) flag 0 latches pass rise, read clears
// (R15) writable pattern high byte, reset zero
// (R16) reserved status and flag bits read zero
// (R17) pass mode selects any or all
// (R18) writable pattern low byte, reset zero
// (R19) interrupt while any enabled flag set
`timescale 1ns/1ps
module cstx_status_irq #(
    parameter int N_PORTS = 2
) (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         addr,
    input  wire logic [7:0]         wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [7:0]         rd_data,
    input  wire logic [N_PORTS-1:0] rx_port_enable,
    input  wire logic [N_PORTS-1:0] rx_port_valid,
    input  wire logic [N_PORTS-1:0] rx_port_irq,
    input  wire logic               sync_fwd_enable,
    input  wire logic               sync_locked,
    input  wire logic               sync_error,
    input  wire logic               tx_error,
    output logic      [15:0]        characterization_pattern,
    output logic      [7:0]         tx_test_control,
    output logic                    irq
);
    localparam int EW = N_PORTS + 2;
    localparam logic RST_LOCAL = cstx_pkg::RST_BIT;

    cstx_evt_if ev ();

    logic [4:0]         irq_enable_reg;
    logic               pass_mode_reg;
    logic [7:0]         test_ctrl_reg;
    logic [7:0]         patt_hi_reg;
    logic [7:0]         patt_lo_reg;
    logic               pass_reg;
    logic               pass_next;
    logic               sync_reg;
    logic               tx_block_reg;
    logic [N_PORTS-1:0] port_ok;
    logic               any_ok;
    logic               all_ok;
    logic               cond_ok;
    logic [EW-1:0]      edge_level;
    logic [EW-1:0]      edge_rise;
    logic [EW-1:0]      edge_fall;
    logic [7:0]         rd_next;

    // only enabled ports count toward the pass condition
    assign port_ok = rx_port_enable & rx_port_valid;
    assign any_ok  = |port_ok;
    assign all_ok  = (|rx_port_enable) & (port_ok == rx_port_enable);

    always_comb begin
        if (pass_mode_reg) begin
            cond_ok = all_ok; // see (R17)
        end else begin
            cond_ok = any_ok; // see (R2)
        end
    end

    // an error blocks pass until the condition drops and returns
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_block_reg <= RST_LOCAL;
        end else if (sync_fwd_enable || !cond_ok) begin
            tx_block_reg <= 1'b0;
        end else if (tx_error) begin
            tx_block_reg <= 1'b1; // see (R3)
        end
    end

    always_comb begin
        if (sync_fwd_enable) begin
            // availability only; delivery may wait for alignment
            pass_next = cond_ok; // see (R4)
        end else begin
            pass_next = cond_ok & ~tx_block_reg & ~tx_error; // see (R3)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pass_reg <= RST_LOCAL;
        end else begin
            pass_reg <= pass_next; // see (R2)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_reg <= RST_LOCAL;
        end else begin
            sync_reg <= sync_fwd_enable & sync_locked; // see (R1)
        end
    end

    assign edge_level = {sync_reg, pass_reg, port_ok};

    cstx_edge_detect #(
        .W (EW)
    ) u_edges (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .level   (edge_level),
        .rise    (edge_rise),
        .fall    (edge_fall)
    );

    // per-port falls, not the combined pass, count as a loss
    always_comb begin
        ev.set                         = cstx_pkg::RST_EVT;
        ev.set[cstx_pkg::EV_PASS_GAIN] = edge_rise[N_PORTS]; // see (R14)
        ev.set[cstx_pkg::EV_PASS_LOSS] = |edge_fall[N_PORTS-1:0]; // see (R13)
        ev.set[cstx_pkg::EV_ALIGNED]   = edge_rise[N_PORTS+1]; // see (R12)
        ev.set[cstx_pkg::EV_ALIGN_ERR] = sync_error; // see (R11)
    end
    assign ev.rx_live = |(rx_port_irq & rx_port_enable); // see (R10)
    assign ev.enable  = irq_enable_reg; // see (R5) see (R6) see (R7) see (R8) see (R9)
    assign ev.rd_clr  = rd_en && (addr == cstx_pkg::ADDR_IRQ_FLAGS); // see (R11)

    always_comb begin
        ev.wr_clr = 5'h00;
        if (wr_en && (addr == cstx_pkg::ADDR_IRQ_CLEAR)) begin
            ev.wr_clr = wr_data[4:0];
        end
    end

    cstx_irq_flags u_flags (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ev      (ev)
    );

    assign irq = ev.irq; // see (R19)

    // register writes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_enable_reg <= cstx_pkg::RST_EVT;
        end else if (wr_en && (addr == cstx_pkg::ADDR_IRQ_EN)) begin
            irq_enable_reg <= wr_data[4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pass_mode_reg <= RST_LOCAL;
        end else if (wr_en && (addr == cstx_pkg::ADDR_PASS_CTRL)) begin
            pass_mode_reg <= wr_data[cstx_pkg::BIT_PASS_MODE]; // see (R17)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            test_ctrl_reg <= cstx_pkg::RST_BYTE;
        end else if (wr_en && (addr == cstx_pkg::ADDR_TEST_CTRL)) begin
            test_ctrl_reg <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            patt_hi_reg <= cstx_pkg::RST_BYTE;
        end else if (wr_en && (addr == cstx_pkg::ADDR_PATT_HI)) begin
            patt_hi_reg <= wr_data; // see (R15)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            patt_lo_reg <= cstx_pkg::RST_BYTE;
        end else if (wr_en && (addr == cstx_pkg::ADDR_PATT_LO)) begin
            patt_lo_reg <= wr_data; // see (R18)
        end
    end

    assign characterization_pattern = {patt_hi_reg, patt_lo_reg};
    assign tx_test_control          = test_ctrl_reg;

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        rd_next = 8'h00;
        case (addr)
            cstx_pkg::ADDR_PASS_CTRL: begin
                rd_next[cstx_pkg::BIT_PASS_MODE] = pass_mode_reg;
            end
            cstx_pkg::ADDR_STATUS: begin
                rd_next[cstx_pkg::BIT_ST_PASS] = pass_reg; // see (R16)
                rd_next[cstx_pkg::BIT_ST_SYNC] = sync_reg;
            end
            cstx_pkg::ADDR_IRQ_EN: begin
                rd_next[4:0] = irq_enable_reg; // see (R16)
            end
            cstx_pkg::ADDR_IRQ_FLAGS: begin
                rd_next[4:0] = ev.flags; // see (R16)
            end
            cstx_pkg::ADDR_TEST_CTRL: begin
                rd_next = test_ctrl_reg;
            end
            cstx_pkg::ADDR_PATT_HI: begin
                rd_next = patt_hi_reg;
            end
            cstx_pkg::ADDR_PATT_LO: begin
                rd_next = patt_lo_reg;
            end
            default: begin
                rd_next = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data <= cstx_pkg::RST_BYTE;
        end else if (rd_en) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= 8'h00;
        end
    end

    a_sync_forced_low: assert property (  // see (R1)
        @(posedge sys_clk) disable iff (sys_rst)
        !sync_fwd_enable |=> !sync_reg
    ) else $error("sync status high while alignment disabled");

    a_pass_any_port: assert property (  // see (R2)
        @(posedge sys_clk) disable iff (sys_rst)
        (sync_fwd_enable && !pass_mode_reg && any_ok) |=> pass_reg
    ) else $error("pass not raised with a valid enabled port");

    a_pass_error_drop: assert property (  // see (R3)
        @(posedge sys_clk) disable iff (sys_rst)
        (!sync_fwd_enable && tx_error) |=> !pass_reg
    ) else $error("pass kept after transmission error");

    a_pass_all_mode: assert property (  // see (R17)
        @(posedge sys_clk) disable iff (sys_rst)
        (pass_mode_reg && !all_ok) |=> !pass_reg
    ) else $error("pass high in all-ports mode with a port missing");

    a_gain_flag_set: assert property (  // see (R14)
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(pass_reg) |=> ev.flags[0]
    ) else $error("pass rise not latched");

    a_loss_flag_set: assert property (  // see (R13)
        @(posedge sys_clk) disable iff (sys_rst)
        (|(rx_port_enable & $past(port_ok) & ~port_ok)) |=> ev.flags[1]
    ) else $error("port pass loss not latched");

    a_read_clears_flags: assert property (  // see (R11)
        @(posedge sys_clk) disable iff (sys_rst)
        (ev.rd_clr && ev.set[3:0] == 4'h0 && ev.wr_clr == 5'h00)
            |=> (ev.flags[3:0] == 4'h0) && (rd_data[4:0] == $past(ev.flags))
    ) else $error("flag read did not return and clear flags");

    a_align_err_irq: assert property (  // see (R6)
        @(posedge sys_clk) disable iff (sys_rst)
        (sync_error && irq_enable_reg[3]) |=> irq
    ) else $error("alignment error did not raise interrupt");

    a_rx_source_mirror: assert property (  // see (R10)
        @(posedge sys_clk) disable iff (sys_rst)
        ev.rx_live |=> ev.flags[4] ##1 (ev.flags[4] == $past(ev.rx_live))
    ) else $error("receive-port flag does not follow sources");

    a_patt_hi_read: assert property (  // see (R15)
        @(posedge sys_clk) disable iff (sys_rst)
        (rd_en && addr == cstx_pkg::ADDR_PATT_HI) |=> rd_data == $past(patt_hi_reg)
    ) else $error("pattern high byte read mismatch");

    a_status_reserved: assert property (  // see (R16)
        @(posedge sys_clk) disable iff (sys_rst)
        (rd_en && addr == cstx_pkg::ADDR_STATUS) |=> rd_data[7:2] == 6'h00
    ) else $error("status reserved bits not zero");

    a_irq_release: assert property (  // see (R19)
        @(posedge sys_clk) disable iff (sys_rst)
        ((ev.flags & irq_enable_reg) == 5'h00) |-> !irq
    ) else $error("interrupt held with no enabled flag");

    a_aligned_flag_set: assert property (  // see (R12)
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(sync_reg) |=> ev.flags[2]
    ) else $error("aligned rise not latched");

    a_align_err_set: assert property (  // see (R11)
        @(posedge sys_clk) disable iff (sys_rst)
        sync_error |=> ev.flags[3]
    ) else $error("alignment error not latched");

    a_sync_level: assert property (  // see (R1)
        @(posedge sys_clk) disable iff (sys_rst)
        (sync_fwd_enable && sync_locked) |=> sync_reg
    ) else $error("sync status low while aligned and enabled");

    a_sync_pass_kept: assert property (  // see (R4)
        @(posedge sys_clk) disable iff (sys_rst)
        (sync_fwd_enable && cond_ok && tx_error) |=> pass_reg
    ) else $error("pass withheld in synchronized forwarding");

    a_patt_lo_read: assert property (  // see (R18)
        @(posedge sys_clk) disable iff (sys_rst)
        (rd_en && addr == cstx_pkg::ADDR_PATT_LO) |=> rd_data == $past(patt_lo_reg)
    ) else $error("pattern low byte read mismatch");

    a_flags_reserved: assert property (  // see (R16)
        @(posedge sys_clk) disable iff (sys_rst)
        (rd_en && addr == cstx_pkg::ADDR_IRQ_FLAGS) |=> rd_data[7:5] == 3'h0
    ) else $error("flag reserved bits not zero");

    a_rx_source_irq: assert property (  // see (R5)
        @(posedge sys_clk) disable iff (sys_rst)
        (ev.rx_live && irq_enable_reg[4] && !(wr_en && addr == cstx_pkg::ADDR_IRQ_EN)) |=> irq
    ) else $error("receive-port interrupt not raised");

    a_event_irq: assert property (  // see (R7) see (R8) see (R9)
        @(posedge sys_clk) disable iff (sys_rst)
        (|(ev.set[2:0] & irq_enable_reg[2:0]) && !(wr_en && addr == cstx_pkg::ADDR_IRQ_EN)) |=> irq
    ) else $error("enabled event did not raise interrupt");
endmodule

// File: test/tb.sv
// self-checking bench for the transmit-port status and interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
    localparam int NP = 2;
    logic          sys_clk;
    logic          sys_rst;
    logic [7:0]    addr;
    logic [7:0]    wr_data;
    logic          wr_en;
    logic          rd_en;
    logic [7:0]    rd_data;
    logic [NP-1:0] rx_port_enable;
    logic [NP-1:0] rx_port_valid;
    logic [NP-1:0] rx_port_irq;
    logic          sync_fwd_enable;
    logic          sync_locked;
    logic          sync_error;
    logic          tx_error;
    logic [15:0]   characterization_pattern;
    logic [7:0]    tx_test_control;
    logic          irq;
    int            n_fail;
    int            n_compared;
    logic [7:0]    exp_q[$];
    logic [7:0]    mon_exp;
    logic          rd_seen;
    logic [7:0]    lfsr_state;

    cstx_status_irq #(.N_PORTS(NP)) i_cstx_status_irq (
        .sys_clk                  (sys_clk),
        .sys_rst                  (sys_rst),
        .addr                     (addr),
        .wr_data                  (wr_data),
        .wr_en                    (wr_en),
        .rd_en                    (rd_en),
        .rd_data                  (rd_data),
        .rx_port_enable           (rx_port_enable),
        .rx_port_valid            (rx_port_valid),
        .rx_port_irq              (rx_port_irq),
        .sync_fwd_enable          (sync_fwd_enable),
        .sync_locked              (sync_locked),
        .sync_error               (sync_error),
        .tx_error                 (tx_error),
        .characterization_pattern (characterization_pattern),
        .tx_test_control          (tx_test_control),
        .irq                      (irq)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // read data only stand for one cycle, so look mid-cycle after the taking edge
    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("mismatch at %0t: read without expectation", $time);
            end else begin
                mon_exp = exp_q.pop_front();
                `CHK(rd_data, mon_exp)
            end
        end
        rd_seen = rd_en;
    end

    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic check_irq(input logic e);
        @(negedge sys_clk);
        `CHK(irq, e)
        @(posedge sys_clk);
    endtask

    // each event starts from the quiet state the previous one left behind
    task automatic fire(input int b);
        case (b)
            0: rx_port_valid <= 2'b01;
            1: rx_port_valid <= 2'b00;
            2: sync_locked <= 1'b1;
            3: begin
                sync_locked <= 1'b0;
                sync_error  <= 1'b1;
                @(posedge sys_clk);
                sync_error  <= 1'b0;
            end
            default: rx_port_irq <= 2'b01;
        endcase
        settle(4);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("mismatch at %0t: run limit reached", $time);
        close_out();
    end

    initial begin
        logic [1:0] en;
        logic [1:0] va;
        logic       p;
        sys_rst = 1'b1; addr = 8'h00; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
        rx_port_enable = 2'b00; rx_port_valid = 2'b00; rx_port_irq = 2'b00;
        sync_fwd_enable = 1'b0; sync_locked = 1'b0; sync_error = 1'b0; tx_error = 1'b0;
        n_fail = 0; n_compared = 0; rd_seen = 1'b0; lfsr_state = 8'h0D;
        settle(16);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(cstx_pkg::ADDR_STATUS, 8'h00);
        rd(cstx_pkg::ADDR_IRQ_EN, 8'h00);
        rd(cstx_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd(cstx_pkg::ADDR_TEST_CTRL, 8'h00);
        rd(cstx_pkg::ADDR_PATT_HI, 8'h00);
        rd(cstx_pkg::ADDR_PATT_LO, 8'h00);
        `CHK(characterization_pattern, 16'h0000)
        check_irq(1'b0);
        for (int i = 0; i < 4; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            wr(cstx_pkg::ADDR_IRQ_EN, lfsr_state);
            rd(cstx_pkg::ADDR_IRQ_EN, lfsr_state & 8'h1F);
            wr(cstx_pkg::ADDR_TEST_CTRL, ~lfsr_state);
            rd(cstx_pkg::ADDR_TEST_CTRL, ~lfsr_state);
            `CHK(tx_test_control, ~lfsr_state)
            wr(cstx_pkg::ADDR_PATT_HI, lfsr_state);
            wr(cstx_pkg::ADDR_PATT_LO, lfsr_state ^ 8'h5A);
            rd(cstx_pkg::ADDR_PATT_HI, lfsr_state);
            rd(cstx_pkg::ADDR_PATT_LO, lfsr_state ^ 8'h5A);
            `CHK(characterization_pattern, {lfsr_state, lfsr_state ^ 8'h5A})
        end
        wr(cstx_pkg::ADDR_STATUS, 8'hFF);
        rd(cstx_pkg::ADDR_STATUS, 8'h00);
        wr(cstx_pkg::ADDR_IRQ_FLAGS, 8'hFF);
        rd(cstx_pkg::ADDR_IRQ_FLAGS, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        // pass level over every enable and valid pairing, both modes
        sync_fwd_enable <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(cstx_pkg::ADDR_PASS_CTRL, (m == 1) ? 8'h08 : 8'h00);
            rd(cstx_pkg::ADDR_PASS_CTRL, (m == 1) ? 8'h08 : 8'h00);
            for (int c = 0; c < 16; c++) begin
                en = 2'(c);
                va = 2'(c >> 2);
                p  = (m == 1) ? ((en != 2'b00) && ((en & va) == en)) : |(en & va);
                rx_port_enable <= en;
                rx_port_valid  <= va;
                settle(3);
                rd(cstx_pkg::ADDR_STATUS, {7'h00, p});
            end
        end
        wr(cstx_pkg::ADDR_PASS_CTRL, 8'h00);
        rx_port_enable <= 2'b01;
        rx_port_valid  <= 2'b00;
        settle(4);
        wr(cstx_pkg::ADDR_IRQ_CLEAR, 8'h1F);
        // each event: masked, then unmasked, then read twice
        for (int b = 0; b < 5; b++) begin
            wr(cstx_pkg::ADDR_IRQ_EN, 8'h1F & ~(8'h01 << b));
            fire(b);
            check_irq(1'b0);
            wr(cstx_pkg::ADDR_IRQ_EN, 8'h01 << b);
            check_irq(1'b1);
            rd(cstx_pkg::ADDR_IRQ_FLAGS, 8'h01 << b);
            rd(cstx_pkg::ADDR_IRQ_FLAGS, (b == 4) ? 8'h10 : 8'h00);
            check_irq(b == 4);
        end
        rx_port_irq <= 2'b00;
        settle(3);
        rd(cstx_pkg::ADDR_IRQ_FLAGS, 8'h00);
        check_irq(1'b0);
        sync_locked <= 1'b1;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h02);
        sync_fwd_enable <= 1'b0;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h00);
        // unsynchronized: an error drops pass until the condition returns
        rx_port_valid <= 2'b01;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h01);
        tx_error <= 1'b1;
        @(posedge sys_clk);
        tx_error <= 1'b0;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h00);
        rx_port_valid <= 2'b00;
        settle(3);
        rx_port_valid <= 2'b01;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h01);
        sync_fwd_enable <= 1'b1;
        settle(3);
        tx_error <= 1'b1;
        @(posedge sys_clk);
        tx_error <= 1'b0;
        settle(3);
        rd(cstx_pkg::ADDR_STATUS, 8'h03);
        // an enabled event raises the line on the next edge, once its flag is registered
        wr(cstx_pkg::ADDR_IRQ_CLEAR, 8'h1F);
        wr(cstx_pkg::ADDR_IRQ_EN, 8'h0F);
        check_irq(1'b0);
        rx_port_valid <= 2'b00;
        settle(2);
        check_irq(1'b1);
        rd(cstx_pkg::ADDR_IRQ_FLAGS, 8'h02);
        settle(2);
        close_out();
    end
endmodule
